// file: hdl/ssr_params.svh
// Purpose: constants for the serial memory read port front end
// Assumes: system clock 200 MHz, serial clock sampled through two flops
// Notes: reset values, opcodes, widths and mode codes for the serial memory front end
// Notes on behaviour
// - Low select enables device; high select means standby with output released.
// - Select rising mid write lets the internal write complete first.
// - Every input bit is sampled on serial clock rising edge.
// - Output changes only after serial clock falling edge.
// - First bit is taken on first rising edge after select falls.
// - Pause low freezes the sequence without losing any progress.
// - Pause acts at once if clock low, else at next falling edge.
// - While paused output is released and clock and input ignored.
// - After pause the command resumes at the exact bit position.
// - First eight bits form the instruction and are decoded as opcode.
// - All fields travel most significant bit first.
// - Opcode 03h reads memory, 02h writes memory, from given address.
// - Opcode 05h reads status, 01h writes status.
// - Sixteen address bits follow; top three ignored, thirteen used.
// - After the last address bit the addressed byte is shifted out.
// - Page mode increments address and wraps within 32-word page.
// - Burst mode increments across array, 1FFFh wraps to 0000h.
// - Status, page and burst reads end only when select rises; word mode read stops after one byte; output released.
// - Mode chosen by writing the status register.
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH
`define SSR_OP_READ      8'h03
`define SSR_OP_WRITE     8'h02
`define SSR_OP_STAT_RD   8'h05
`define SSR_OP_STAT_WR   8'h01
`define SSR_ADDR_W       13
`define SSR_DEPTH        8192
`define SSR_PAGE_W       5
`define SSR_INSTR_BITS   5'h08
`define SSR_ADDR_BITS    5'h10
`define SSR_LAST_BIT     3'h7
`define SSR_MODE_LSB     6
`define SSR_MODE_WORD    2'h0
`define SSR_MODE_PAGE    2'h2
`define SSR_MODE_BURST   2'h1
`define SSR_STAT_RESET   8'h02
`define SSR_STAT_WMASK   8'hC1
`define SSR_STAT_FIXED   8'h02
`endif

// file: hdl/ssr_pkg.sv
// Purpose: types for the serial memory read port front end
// Assumes: included constants header
// Notes: state is one packed struct
package ssr_pkg;
    typedef enum logic [2:0] {
        SSR_IDLE  = 3'b000,
        SSR_INSTR = 3'b001,
        SSR_ADDR  = 3'b010,
        SSR_RDATA = 3'b011,
        SSR_WDATA = 3'b100,
        SSR_SRD   = 3'b101,
        SSR_SWR   = 3'b110,
        SSR_DONE  = 3'b111
    } ssr_phase_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
    } ssr_pins_t;

    typedef struct packed {
        logic so;
        logic so_oe;
    } ssr_out_t;

    typedef struct packed {
        ssr_pins_t  s1;
        ssr_pins_t  s2;
        logic       sck_prev;
        logic       paused;
        ssr_phase_t phase;
        logic [7:0] op;
        logic [4:0] cnt;
        logic [15:0] shin;
        logic [12:0] addr;
        logic [7:0] shout;
        logic [7:0] status;
        logic       driving;
        logic       so_bit;
        logic       wr_pend;
        logic [12:0] wr_addr;
        logic [7:0] wr_data;
    } ssr_state_t;
endpackage : ssr_pkg

// file: hdl/ssr_core.sv
// Purpose: serial memory front end: framing, decode, address, read and write shifting, pause
// Assumes: pins asynchronous to clock; serial clock well under a quarter of clock
// Notes: memory array held here; output driven with enable
`timescale 1ns/1ps
`include "ssr_params.svh"
module ssr_core (
    input  wire logic          clock,
    input  wire logic          arst_n,
    input  wire ssr_pkg::ssr_pins_t pins,
    output ssr_pkg::ssr_out_t  so_pin,
    output logic               selected,
    output logic               paused
);
    import ssr_pkg::*;

    ssr_state_t q, d;
    logic [7:0] mem [0:`SSR_DEPTH-1];
    logic       rise, fall, sel, do_write;

    // Mode field of the status byte
    function automatic logic [1:0] mode_of(input logic [7:0] s);
        return s[`SSR_MODE_LSB +: 2];
    endfunction : mode_of

    // Next address by mode
    function automatic logic [12:0] next_addr(input logic [12:0] a, input logic [1:0] m);
        logic [12:0] n;
        n = a;
        if (m == `SSR_MODE_PAGE) begin
            n[`SSR_PAGE_W-1:0] = a[`SSR_PAGE_W-1:0] + 5'h01;
        end else if (m == `SSR_MODE_BURST) begin
            n = a + 13'h0001;
        end
        return n;
    endfunction : next_addr

    always_ff @(posedge clock) begin
        if (do_write) begin
            mem[q.wr_addr] <= q.wr_data;
        end
    end
    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.sck_prev = q.s2.sck;
        sel = !q.s2.cs_n;
        rise = sel && !q.paused && q.s2.sck && !q.sck_prev;
        fall = sel && q.s2.sck == 1'b0 && q.sck_prev;
        do_write = q.wr_pend;
        d.wr_pend = 1'b0;
        // Pause entry and exit
        if (!sel) begin
            d.paused = 1'b0;
        end else if (!q.s2.hold_n && (!q.s2.sck || fall)) begin
            d.paused = 1'b1;
        end else if (q.s2.hold_n && !q.s2.sck) begin
            d.paused = 1'b0;
        end
        if (!sel) begin
            d.phase = SSR_IDLE;
            d.cnt = 5'h00;
            d.driving = 1'b0;
        end else begin
            if (q.phase == SSR_IDLE) begin
                d.phase = SSR_INSTR;
                d.cnt = 5'h00;
            end
            if (rise) begin
                d.shin = {q.shin[14:0], q.s2.si};
                d.cnt = q.cnt + 5'h01;
                case (q.phase)
                    SSR_IDLE, SSR_INSTR: begin
                        d.phase = SSR_INSTR;
                        d.cnt = (q.phase == SSR_IDLE) ? 5'h01 : q.cnt + 5'h01;
                        if (d.cnt == `SSR_INSTR_BITS) begin
                            d.op = d.shin[7:0];
                            d.cnt = 5'h00;
                            if (d.op == `SSR_OP_READ || d.op == `SSR_OP_WRITE) begin
                                d.phase = SSR_ADDR;
                            end else if (d.op == `SSR_OP_STAT_RD) begin
                                d.phase = SSR_SRD;
                                d.shout = q.status;
                            end else if (d.op == `SSR_OP_STAT_WR) begin
                                d.phase = SSR_SWR;
                            end else begin
                                d.phase = SSR_DONE;
                            end
                        end
                    end
                    SSR_ADDR: begin
                        if (d.cnt == `SSR_ADDR_BITS) begin
                            d.addr = d.shin[`SSR_ADDR_W-1:0];
                            d.cnt = 5'h00;
                            d.phase = (q.op == `SSR_OP_READ) ? SSR_RDATA : SSR_WDATA;
                            d.shout = mem[d.addr];
                        end
                    end
                    SSR_RDATA, SSR_SRD: begin
                        if (d.cnt[2:0] == 3'h0) begin
                            d.cnt = 5'h00;
                            if (q.phase == SSR_RDATA) begin
                                if (mode_of(q.status) == `SSR_MODE_WORD) begin
                                    d.phase = SSR_DONE;
                                end else begin
                                    d.addr = next_addr(q.addr, mode_of(q.status));
                                    d.shout = mem[d.addr];
                                end
                            end else begin
                                d.shout = q.status;
                            end
                        end
                    end
                    SSR_WDATA: begin
                        if (d.cnt[2:0] == 3'h0) begin
                            d.cnt = 5'h00;
                            d.wr_pend = 1'b1;
                            d.wr_addr = q.addr;
                            d.wr_data = d.shin[7:0];
                            if (mode_of(q.status) == `SSR_MODE_WORD) begin
                                d.phase = SSR_DONE;
                            end else begin
                                d.addr = next_addr(q.addr, mode_of(q.status));
                            end
                        end
                    end
                    SSR_SWR: begin
                        if (d.cnt[2:0] == 3'h0) begin
                            d.status = (d.shin[7:0] & `SSR_STAT_WMASK) | `SSR_STAT_FIXED;
                            d.phase = SSR_DONE;
                        end
                    end
                    default: begin
                        d.cnt = q.cnt;
                    end
                endcase
            end
            if (fall && !q.paused) begin
                // Output moves only on falling edge
                if ((q.phase == SSR_RDATA || q.phase == SSR_SRD) && q.cnt[2:0] <= `SSR_LAST_BIT) begin
                    d.so_bit = q.shout[`SSR_LAST_BIT - q.cnt[2:0]];
                    d.driving = 1'b1;
                end else begin
                    d.driving = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{s1: '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1},
                   s2: '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1},
                   phase: SSR_IDLE, status: `SSR_STAT_RESET, default: '0};
        end else begin
            q <= d;
        end
    end

    assign so_pin.so    = q.so_bit;
    assign so_pin.so_oe = q.driving && sel && !q.paused && q.s2.hold_n;
    assign selected     = sel;
    assign paused       = q.paused;
endmodule : ssr_core

// file: tb/ssr_core_assertions.sv
// Purpose: pin level checks of the serial memory front end
// Assumes: pins held several clocks between edges
// Notes: bound to ssr_core
`timescale 1ns/1ps
module ssr_core_assertions (
    input logic               clock,
    input logic               arst_n,
    input ssr_pkg::ssr_pins_t pins,
    input ssr_pkg::ssr_out_t  so_pin,
    input logic               selected,
    input logic               paused
);
    import ssr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_pause_req;
        (!pins.hold_n && !pins.sck && !pins.cs_n)[*6];
    endsequence
    sequence s_resume_req;
        (pins.hold_n && !pins.sck)[*6];
    endsequence
    sequence s_sck_high_driving;
        pins.sck[*5] ##0 so_pin.so_oe;
    endsequence
    AST_STANDBY_QUIET: assert property (pins.cs_n[*5] |-> !so_pin.so_oe)
        else $error("output driven in standby");
    AST_SELECT_TRACKS: assert property ((!pins.cs_n)[*5] |-> selected)
        else $error("select low not seen");
    AST_DESELECT: assert property (pins.cs_n[*5] |-> !selected)
        else $error("select high not seen");
    AST_HOLD_QUIET: assert property ((!pins.hold_n)[*5] |-> !so_pin.so_oe)
        else $error("output driven while held");
    AST_SO_STEADY: assert property (s_sck_high_driving |-> $stable(so_pin.so))
        else $error("output moved with clock high");
    AST_PAUSE_CAUSE: assert property ($rose(paused) |-> !pins.hold_n)
        else $error("pause without hold");
    AST_PAUSE_ENTRY: assert property (s_pause_req |-> paused)
        else $error("pause not taken");
    AST_RESUME: assert property (s_resume_req |-> !paused)
        else $error("pause not left");
    AST_PAUSED_NO_OE: assert property (paused |-> !so_pin.so_oe)
        else $error("output driven while paused");
endmodule : ssr_core_assertions
bind ssr_core ssr_core_assertions chk_u (.clock(clock), .arst_n(arst_n), .pins(pins),
    .so_pin(so_pin), .selected(selected), .paused(paused));

// file: tb/ssr_host_model.sv
// Purpose: serial controller model driving the memory pins
// Assumes: link half period 24 ns
// Notes: data line shows inverse of last bit outside frames
`timescale 1ns/1ps
module ssr_host_model (
    output ssr_pkg::ssr_pins_t pins,
    input  ssr_pkg::ssr_out_t  so_pin
);
    import ssr_pkg::*;
    initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.si = tx[i];
            #24 pins.sck = 1'b1;
            rx[i] = so_pin.so_oe ? so_pin.so : 1'bx;
            #24 pins.sck = 1'b0;
        end
    endtask : xfer
    task automatic frame(input logic [7:0] op, input logic [15:0] a, input logic use_a, hold,
                         input logic [7:0] d0, d1, output logic [7:0] r0, r1);
        logic [7:0] x;
        pins.cs_n = 1'b0;
        #24 xfer(op, x);
        if (use_a)
            xfer(a[15:8], x);
        if (hold) begin
            pins.hold_n = 1'b0;
            #48 pins.sck = 1'b1;
            #24 pins.sck = 1'b0;
            #48 pins.hold_n = 1'b1;
            #24;
        end
        if (use_a)
            xfer(a[7:0], x);
        xfer(d0, r0);
        xfer(d1, r1);
        #24 pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        #72;
    endtask : frame
endmodule : ssr_host_model

// file: tb/serial_sram_spi_read_port_tb_top.sv
// Purpose: self-checking bench of the serial memory front end
// Assumes: controller model drives the pins
// Notes: status, page wrap, burst wrap with pause
`timescale 1ns/1ps
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module serial_sram_spi_read_port_tb_top;
    import ssr_pkg::*;
    logic      clock;
    logic      arst_n;
    ssr_pins_t pins;
    ssr_out_t  so_pin;
    logic      selected;
    logic      paused;
    int        failures;
    int        total_checks;
    ssr_core dut_u (.clock(clock), .arst_n(arst_n), .pins(pins), .so_pin(so_pin),
        .selected(selected), .paused(paused));
    ssr_host_model host_u (.pins(pins), .so_pin(so_pin));
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic t_status_reset;
        logic [7:0] r0, r1;
        host_u.frame(8'h05, 16'h0, 1'b0, 1'b0, 8'h00, 8'h00, r0, r1);
        `CHECK(r0, 8'h02)
    endtask : t_status_reset
    task automatic t_page_wrap;
        logic [7:0] r0, r1;
        host_u.frame(8'h01, 16'h0, 1'b0, 1'b0, 8'h80, 8'h80, r0, r1);
        host_u.frame(8'h05, 16'h0, 1'b0, 1'b0, 8'h00, 8'h00, r0, r1);
        `CHECK(r0, 8'h82)
        host_u.frame(8'h02, 16'hE05F, 1'b1, 1'b0, 8'h11, 8'h22, r0, r1);
        host_u.frame(8'h03, 16'h005F, 1'b1, 1'b0, 8'h00, 8'h00, r0, r1);
        `CHECK(r0, 8'h11)
        `CHECK(r1, 8'h22)
    endtask : t_page_wrap
    task automatic t_burst_pause;
        logic [7:0] r0, r1;
        host_u.frame(8'h01, 16'h0, 1'b0, 1'b0, 8'h40, 8'h40, r0, r1);
        host_u.frame(8'h02, 16'hFFFF, 1'b1, 1'b0, 8'hA5, 8'h3C, r0, r1);
        fork
            host_u.frame(8'h03, 16'h1FFF, 1'b1, 1'b1, 8'h00, 8'h00, r0, r1);
            begin
                #850;
                `CHECK({paused, so_pin.so_oe}, 2'b10)
            end
        join
        `CHECK(r0, 8'hA5)
        `CHECK(r1, 8'h3C)
    endtask : t_burst_pause
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        arst_n = 1'b0;
        repeat (16) @(negedge clock);
        `CHECK({so_pin.so_oe, selected, paused}, 3'b000)
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_status_reset;
        t_page_wrap;
        t_burst_pause;
        summarize;
    end
    initial begin
        #200000;
        failures++;
        summarize;
    end
endmodule : serial_sram_spi_read_port_tb_top
